// ### hw/rrse_pkg.sv
// shared constants and carrier types for the return, rotate and sleep executor
package rrse_pkg;

    // ==========================================================
    // widths and depths
    localparam int IP_W = 13;
    localparam int STK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam int STK_CNT_W = 4;
    localparam int FILE_DEPTH = 128;
    localparam int FILE_ADDR_W = 7;

    // ==========================================================
    // operation codes of the issue port
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_RET_LIT = 4'h1;
    localparam logic [3:0] OP_RETURN = 4'h2;
    localparam logic [3:0] OP_ROT_LEFT = 4'h3;
    localparam logic [3:0] OP_SLEEP = 4'h4;

    // destination select of the rotate
    localparam logic DEST_ACC = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_ACC = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_IP_LO = 8'h02;
    localparam logic [7:0] REG_IP_HI = 8'h03;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_WDOG = 8'h05;
    localparam logic [7:0] REG_STK_LO = 8'h06;
    localparam logic [7:0] REG_STK_HI = 8'h07;
    localparam logic [7:0] REG_STK_CNT = 8'h08;
    localparam logic [7:0] REG_PRESC = 8'h09;
    // file registers occupy the upper half of the map
    localparam int FILE_SEL_BIT = 7;

    // ==========================================================
    // status and control field positions
    localparam int ST_CARRY = 0;
    localparam int ST_EXPIRY = 1;
    localparam int ST_PDOWN = 2;
    localparam int ST_SLEEP = 3;
    localparam int CTRL_WDOG_EN = 0;

    // ==========================================================
    // reset values and counter maxima
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [IP_W-1:0] IP_RST = 13'h0000;
    localparam logic EXPIRY_RST = 1'h1;
    localparam logic PDOWN_RST = 1'h1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] WDOG_RST = 8'h00;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic [7:0] PRESC_MAX = 8'hFF;
    localparam logic [7:0] WDOG_MAX = 8'hFF;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [3:0] op;
        logic dest;
        logic [FILE_ADDR_W-1:0] addr;
        logic [7:0] lit;
    } rrse_instr_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rrse_bus_t;

    typedef enum logic [2:0] {
        S_RUN = 3'b001,
        S_SECOND = 3'b010,
        S_SLEEP = 3'b100
    } rrse_state_t;

endpackage : rrse_pkg

// ### hw/rrse_exec.sv
// executor for return-with-literal, return, rotate-left and sleep
// Overview of operation
// - return-with-literal loads accumulator with literal
// - it reloads pointer from stack top, pops
// - one word, two cycles, flags untouched
// - return pops stack into pointer, flags untouched
// - return takes two instruction cycles
// - rotate file register left through carry only
// - destination bit picks accumulator or file register
// - rotate is one word, one cycle
// - sleep clears watchdog counter and prescaler
// - sleep sets watchdog expiry flag
// - sleep clears power-down flag
// - then sleep stops oscillator, enters sleep
`timescale 1ns/1ps

module rrse_exec
    import rrse_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire rrse_bus_t bus,
    output logic [7:0] rdata_q,
    input wire logic instr_valid,
    input wire rrse_instr_t instr,
    output logic instr_ready_q,
    output logic instr_done_q,
    input wire logic wake,
    output logic [IP_W-1:0] instr_pointer_q,
    output logic [7:0] acc_q,
    output logic sleeping_q,
    output logic osc_run_q
);

    // ==========================================================
    // state
    rrse_state_t state_q;
    logic [7:0] file_q [FILE_DEPTH];
    logic [IP_W-1:0] stack_q [STK_DEPTH];
    logic [STK_PTR_W-1:0] stk_ptr_q;
    logic [STK_CNT_W-1:0] stk_cnt_q;
    logic [7:0] stk_lo_q;
    logic carry_q;
    logic expiry_flag_q;
    logic power_down_flag_q;
    logic [7:0] ctrl_q;
    logic [7:0] watchdog_counter_q;
    logic [7:0] presc_q;

    // ==========================================================
    // decode
    logic accept;
    logic do_ret_lit;
    logic do_return;
    logic do_rot;
    logic do_sleep;
    logic do_pop;
    logic [7:0] rot_src;
    logic [7:0] rot_res;
    logic bus_file;
    logic bus_push;
    logic [STK_PTR_W-1:0] top_idx;
    logic [IP_W-1:0] stack_top;

    assign accept = instr_valid && instr_ready_q;
    assign do_ret_lit = accept && (instr.op == OP_RET_LIT);
    assign do_return = accept && (instr.op == OP_RETURN);
    assign do_rot = accept && (instr.op == OP_ROT_LEFT);
    assign do_sleep = accept && (instr.op == OP_SLEEP);
    assign do_pop = do_ret_lit || do_return;
    assign rot_src = file_q[instr.addr];
    assign rot_res = {rot_src[6:0], carry_q};
    assign bus_file = bus.addr[FILE_SEL_BIT];
    // a push from software that meets a pop is dropped to keep one pointer move a cycle
    assign bus_push = bus.wr && !bus_file && (bus.addr == REG_STK_HI) && !do_pop;
    assign top_idx = stk_ptr_q - 3'h1;
    assign stack_top = stack_q[top_idx];

    // ==========================================================
    // sequencing
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= S_RUN;
        end else begin
            unique case (state_q)
                S_RUN: begin
                    if (do_pop) begin
                        // returns hold the issue port for a second cycle
                        state_q <= S_SECOND;
                    end else if (do_sleep) begin
                        state_q <= S_SLEEP;
                    end
                end
                S_SECOND: begin
                    state_q <= S_RUN;
                end
                S_SLEEP: begin
                    if (wake) begin
                        state_q <= S_RUN;
                    end
                end
                default: begin
                    state_q <= S_RUN;
                end
            endcase
        end
    end

    // ready drops for the second cycle of a return and for all of sleep
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            instr_ready_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_RUN: begin
                    instr_ready_q <= !(do_pop || do_sleep);
                end
                S_SECOND: begin
                    instr_ready_q <= 1'b1;
                end
                S_SLEEP: begin
                    instr_ready_q <= wake;
                end
                default: begin
                    instr_ready_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            instr_done_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_RUN: begin
                    instr_done_q <= accept && !do_pop;
                end
                S_SECOND: begin
                    instr_done_q <= 1'b1;
                end
                S_SLEEP: begin
                    instr_done_q <= 1'b0;
                end
                default: begin
                    instr_done_q <= 1'b0;
                end
            endcase
        end
    end

    // sleep flag and stopped oscillator come and go together
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleeping_q <= 1'b0;
        end else if (do_sleep) begin
            sleeping_q <= 1'b1;
        end else if (state_q == S_SLEEP && wake) begin
            sleeping_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_run_q <= 1'b1;
        end else if (do_sleep) begin
            osc_run_q <= 1'b0;
        end else if (state_q == S_SLEEP && wake) begin
            osc_run_q <= 1'b1;
        end
    end

    // ==========================================================
    // accumulator
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_q <= ACC_RST;
        end else if (do_ret_lit) begin
            acc_q <= instr.lit;
        end else if (do_rot && instr.dest == DEST_ACC) begin
            acc_q <= rot_res;
        end else if (bus.wr && bus.addr == REG_ACC) begin
            acc_q <= bus.wdata;
        end
    end

    // ==========================================================
    // file registers, no reset so they map onto plain storage
    always_ff @(posedge clock) begin
        if (do_rot && instr.dest == DEST_FILE) begin
            file_q[instr.addr] <= rot_res;
        end else if (bus.wr && bus_file) begin
            file_q[bus.addr[FILE_ADDR_W-1:0]] <= bus.wdata;
        end
    end

    // ==========================================================
    // carry: only the rotate touches it among the four operations
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            carry_q <= 1'b0;
        end else if (do_rot) begin
            carry_q <= rot_src[7];
        end else if (bus.wr && bus.addr == REG_STATUS) begin
            carry_q <= bus.wdata[ST_CARRY];
        end
    end

    // ==========================================================
    // instruction pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            instr_pointer_q <= IP_RST;
        end else if (do_pop) begin
            instr_pointer_q <= stack_top;
        end else if (accept) begin
            instr_pointer_q <= instr_pointer_q + 13'h0001;
        end else if (bus.wr && bus.addr == REG_IP_LO) begin
            instr_pointer_q[7:0] <= bus.wdata;
        end else if (bus.wr && bus.addr == REG_IP_HI) begin
            instr_pointer_q[IP_W-1:8] <= bus.wdata[IP_W-9:0];
        end
    end

    // ==========================================================
    // return stack: circular, so an empty pop wraps like the pointer does
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stk_ptr_q <= '0;
            stk_cnt_q <= '0;
            stk_lo_q <= 8'h00;
        end else begin
            if (bus.wr && bus.addr == REG_STK_LO) begin
                stk_lo_q <= bus.wdata;
            end
            if (do_pop) begin
                stk_ptr_q <= top_idx;
                if (stk_cnt_q != '0) begin
                    stk_cnt_q <= stk_cnt_q - 4'h1;
                end
            end else if (bus_push) begin
                stk_ptr_q <= stk_ptr_q + 3'h1;
                if (stk_cnt_q != 4'(STK_DEPTH)) begin
                    stk_cnt_q <= stk_cnt_q + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (bus_push) begin
            stack_q[stk_ptr_q] <= {bus.wdata[IP_W-9:0], stk_lo_q};
        end
    end

    // ==========================================================
    // control
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else if (bus.wr && bus.addr == REG_CTRL) begin
            ctrl_q <= bus.wdata;
        end
    end

    // ==========================================================
    // watchdog: prescaler wrap is the enable pulse for the counter
    logic presc_wrap;
    logic wdog_timeout;

    assign presc_wrap = ctrl_q[CTRL_WDOG_EN] && (presc_q == PRESC_MAX);
    assign wdog_timeout = presc_wrap && (watchdog_counter_q == WDOG_MAX);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            presc_q <= PRESC_RST;
        end else if (do_sleep) begin
            presc_q <= PRESC_RST;
        end else if (ctrl_q[CTRL_WDOG_EN]) begin
            presc_q <= presc_q + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            watchdog_counter_q <= WDOG_RST;
        end else if (do_sleep) begin
            watchdog_counter_q <= WDOG_RST;
        end else if (presc_wrap) begin
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
        end
    end

    // ==========================================================
    // status flags: sleep wins over a timeout in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            expiry_flag_q <= EXPIRY_RST;
            power_down_flag_q <= PDOWN_RST;
        end else begin
            if (do_sleep) begin
                expiry_flag_q <= 1'b1;
                power_down_flag_q <= 1'b0;
            end else if (wdog_timeout) begin
                expiry_flag_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register read port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            if (bus_file) begin
                rdata_q <= file_q[bus.addr[FILE_ADDR_W-1:0]];
            end else begin
                unique case (bus.addr)
                    REG_ACC: rdata_q <= acc_q;
                    REG_STATUS: rdata_q <= {4'h0, sleeping_q, power_down_flag_q,
                        expiry_flag_q, carry_q};
                    REG_IP_LO: rdata_q <= instr_pointer_q[7:0];
                    REG_IP_HI: rdata_q <= {3'h0, instr_pointer_q[IP_W-1:8]};
                    REG_CTRL: rdata_q <= ctrl_q;
                    REG_WDOG: rdata_q <= watchdog_counter_q;
                    REG_STK_LO: rdata_q <= stack_top[7:0];
                    REG_STK_HI: rdata_q <= {3'h0, stack_top[IP_W-1:8]};
                    REG_STK_CNT: rdata_q <= {4'h0, stk_cnt_q};
                    REG_PRESC: rdata_q <= presc_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end

endmodule : rrse_exec

// ### testbench/rrse_exec_monitor.sv
// port checker for the return, rotate and sleep executor
`timescale 1ns/1ps
module rrse_exec_monitor
    import rrse_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire rrse_bus_t bus,
    input wire logic [7:0] rdata_q,
    input wire logic instr_valid,
    input wire rrse_instr_t instr,
    input wire logic instr_ready_q,
    input wire logic instr_done_q,
    input wire logic wake,
    input wire logic [IP_W-1:0] instr_pointer_q,
    input wire logic [7:0] acc_q,
    input wire logic sleeping_q,
    input wire logic osc_run_q
);
    // ==========================================================
    // helpers
    logic take;
    logic acc_wr;
    assign take = instr_valid && instr_ready_q;
    // a bus write to the accumulator may legally land beside an instruction
    assign acc_wr = bus.wr && (bus.addr == REG_ACC);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // assertions
    chk_lit_acc: assert property (take && instr.op == OP_RET_LIT |=> acc_q == $past(instr.lit))
        else $error("accumulator missed the literal");
    chk_ret_two: assert property (take && (instr.op == OP_RET_LIT || instr.op == OP_RETURN)
        |=> !instr_ready_q && !instr_done_q ##1 instr_done_q)
        else $error("return did not take two cycles");
    chk_ret_acc: assert property (take && instr.op == OP_RETURN && !acc_wr |=> $stable(acc_q))
        else $error("return changed the accumulator");
    chk_rot_one: assert property (take && instr.op == OP_ROT_LEFT
        |=> instr_done_q && instr_pointer_q == $past(instr_pointer_q) + 13'h0001)
        else $error("rotate not done in one cycle");
    chk_rot_file: assert property (take && instr.op == OP_ROT_LEFT && instr.dest == DEST_FILE
        && !acc_wr |=> $stable(acc_q))
        else $error("file rotate wrote the accumulator");
    chk_sleep_enter: assert property (take && instr.op == OP_SLEEP
        |=> sleeping_q && !osc_run_q && instr_done_q)
        else $error("sleep not entered");
    chk_osc_off: assert property (sleeping_q |-> !osc_run_q)
        else $error("oscillator runs while asleep");
    chk_sleep_hold: assert property (sleeping_q && !wake |=> sleeping_q && !instr_ready_q)
        else $error("sleep left without wake");
    chk_wake_run: assert property (sleeping_q && wake |=> !sleeping_q && osc_run_q)
        else $error("wake did not restart");
endmodule : rrse_exec_monitor

bind rrse_exec rrse_exec_monitor u_mon (.clock(clock), .rst(rst), .bus(bus), .rdata_q(rdata_q),
    .instr_valid(instr_valid), .instr(instr), .instr_ready_q(instr_ready_q),
    .instr_done_q(instr_done_q), .wake(wake), .instr_pointer_q(instr_pointer_q),
    .acc_q(acc_q), .sleeping_q(sleeping_q), .osc_run_q(osc_run_q));

// ### testbench/return_rotate_sleep_exec_tb_top.sv
// self-checking bench for the return, rotate and sleep executor
`timescale 1ns/1ps
module return_rotate_sleep_exec_tb_top
    import rrse_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    rrse_bus_t bus = '0;
    logic instr_valid = 1'b0;
    rrse_instr_t instr = '0;
    logic wake = 1'b0;
    logic [7:0] rdata_q;
    logic [7:0] acc_q;
    logic instr_ready_q;
    logic instr_done_q;
    logic sleeping_q;
    logic osc_run_q;
    logic [IP_W-1:0] instr_pointer_q;
    int error_cnt = 0;
    int total_checks = 0;

    always #2.5 clock = ~clock;

    rrse_exec DUT (.clock(clock), .rst(rst), .bus(bus), .rdata_q(rdata_q),
        .instr_valid(instr_valid), .instr(instr), .instr_ready_q(instr_ready_q),
        .instr_done_q(instr_done_q), .wake(wake), .instr_pointer_q(instr_pointer_q),
        .acc_q(acc_q), .sleeping_q(sleeping_q), .osc_run_q(osc_run_q));

    // ==========================================================
    // shared tasks, all entered just after a rising edge
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // the idle cycle after each access keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
        @(posedge clock);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata_q;
        @(posedge clock);
        cmp(nm, {8'h00, e}, {8'h00, d});
    endtask : rdc

    task automatic push(input logic [IP_W-1:0] v);
        wr(REG_STK_LO, v[7:0]);
        wr(REG_STK_HI, {3'h0, v[12:8]});
    endtask : push

    // values read right after an edge are those the design sampled there
    task automatic issue(input logic [3:0] op, input logic d, input logic [6:0] a,
        input logic [7:0] k, input logic [15:0] cyc, input logic [IP_W-1:0] ip);
        logic [15:0] n;
        instr_valid <= 1'b1;
        instr <= '{op: op, dest: d, addr: a, lit: k};
        for (int i = 0; i < 20; i++) begin
            @(posedge clock);
            if (instr_ready_q === 1'b1) break;
        end
        instr_valid <= 1'b0;
        for (n = 16'h0001; n < 16'h0006; n++) begin
            @(posedge clock);
            if (instr_done_q === 1'b1) break;
        end
        cmp("latency", cyc, n);
        cmp("pointer", {3'h0, ip}, {3'h0, instr_pointer_q});
    endtask : issue

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdc("status", REG_STATUS, 8'h06);
        rdc("acc", REG_ACC, 8'h00);
    endtask : t_reset

    task automatic t_ret_lit();
        push(13'h1234);
        rdc("depth", REG_STK_CNT, 8'h01);
        issue(OP_RET_LIT, 1'b0, 7'h00, 8'hFF, 16'h0002, 13'h1234);
        rdc("acc", REG_ACC, 8'hFF);
        rdc("depth", REG_STK_CNT, 8'h00);
        rdc("status", REG_STATUS, 8'h06);
    endtask : t_ret_lit

    task automatic t_return();
        wr(REG_ACC, 8'h5A);
        push(13'h0ABC);
        issue(OP_RETURN, 1'b0, 7'h00, 8'h00, 16'h0002, 13'h0ABC);
        rdc("acc", REG_ACC, 8'h5A);
        rdc("status", REG_STATUS, 8'h06);
    endtask : t_return

    task automatic t_rotate();
        wr(8'hFF, 8'hE6);
        wr(REG_STATUS, 8'h00);
        issue(OP_ROT_LEFT, DEST_ACC, 7'h7F, 8'h00, 16'h0001, 13'h0ABD);
        rdc("acc", REG_ACC, 8'hCC);
        rdc("status", REG_STATUS, 8'h07);
        rdc("file", 8'hFF, 8'hE6);
        issue(OP_ROT_LEFT, DEST_FILE, 7'h7F, 8'h00, 16'h0001, 13'h0ABE);
        rdc("file", 8'hFF, 8'hCD);
        rdc("acc", REG_ACC, 8'hCC);
        rdc("status", REG_STATUS, 8'h07);
        // an idle op only steps the pointer
        issue(OP_NOP, 1'b0, 7'h00, 8'h00, 16'h0001, 13'h0ABF);
        rdc("status", REG_STATUS, 8'h07);
    endtask : t_rotate

    task automatic t_sleep();
        // let the watchdog time out once so the expiry flag is really set again
        wr(REG_CTRL, 8'h01);
        repeat (65800) @(posedge clock);
        rdc("status", REG_STATUS, 8'h05);
        wr(REG_CTRL, 8'h00);
        issue(OP_SLEEP, 1'b0, 7'h00, 8'h00, 16'h0001, 13'h0AC0);
        #1 cmp("sleep_osc", 16'h0002, {14'h0000, sleeping_q, osc_run_q});
        @(posedge clock);
        rdc("wdog", REG_WDOG, 8'h00);
        rdc("presc", REG_PRESC, 8'h00);
        rdc("status", REG_STATUS, 8'h0B);
        wake <= 1'b1;
        @(posedge clock);
        wake <= 1'b0;
        #1 cmp("sleep_osc", 16'h0001, {14'h0000, sleeping_q, osc_run_q});
        @(posedge clock);
        rdc("status", REG_STATUS, 8'h03);
    endtask : t_sleep

    // ==========================================================
    // verdict
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    initial begin
        #450000;
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_ret_lit();
        t_return();
        t_rotate();
        t_sleep();
        close_out();
    end
endmodule : return_rotate_sleep_exec_tb_top
